// ### rtl/qdf_params.svh
`ifndef QDF_PARAMS_SVH
`define QDF_PARAMS_SVH
// ==========================================
// Channel counts
`define QDF_NCH 4
`define QDF_NPAIR 6
// ==========================================
// Timing
`define QDF_CLK_HZ 10000000
`define QDF_SAMPLE_HZ 100000
`define QDF_OUT_HZ 1000
`define QDF_SAMPLE_CYC (`QDF_CLK_HZ / `QDF_SAMPLE_HZ)
`define QDF_DECIM_N (`QDF_SAMPLE_HZ / `QDF_OUT_HZ)
`define QDF_LED_SLOW_MS 2000
`define QDF_LED_FAST_MS 500
`define QDF_LED_SLOW_CYC (`QDF_CLK_HZ / 1000 * `QDF_LED_SLOW_MS)
`define QDF_LED_FAST_CYC (`QDF_CLK_HZ / 1000 * `QDF_LED_FAST_MS)
// ==========================================
// Register byte offsets
`define QDF_REG_CTRL 8'h00
`define QDF_REG_STATUS 8'h04
`define QDF_REG_WINDOW 8'h08
`define QDF_REG_SPAN 8'h0C
`define QDF_REG_ABS_THR 8'h10
`define QDF_REG_PAIR_THR 8'h20
`define QDF_REG_OFFSET 8'h40
`define QDF_REG_READING 8'h50
// ==========================================
// Field positions
`define QDF_CTRL_CORR 0
`define QDF_CTRL_ASCII 1
`define QDF_CTRL_TRIG 2
`define QDF_CTRL_SAVE 3
`define QDF_CTRL_LOAD 4
`define QDF_STAT_PAIR_LSB 4
`define QDF_STAT_ILK 10
`define QDF_STAT_BOOT 11
`define QDF_STAT_NVM 12
// ==========================================
// Reset values and limits
`define QDF_WIN_RST 4'h4
`define QDF_WIN_MAX 4'h8
`define QDF_SPAN_RST 4'h0
`define QDF_SPAN_MAX 4'hA
`define QDF_ABS_THR_RST 24'h7FFFFF
`define QDF_PAIR_THR_RST 24'hFFFFFF
`define QDF_OFFSET_RST 24'h000000
`endif

// ### rtl/qdf_pkg.sv
package qdf_pkg;
	// ==========================================
	// Types
	// One simultaneous conversion of all channels
	typedef struct packed {
		logic valid;
		logic [3:0][23:0] data;
	} qdf_adc_s;
	// Request toward the non-volatile store
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] addr;
		logic [23:0] wdata;
	} qdf_nvm_req_s;
	// Answer from the non-volatile store
	typedef struct packed {
		logic ack;
		logic [23:0] rdata;
	} qdf_nvm_rsp_s;
	// Sequencer for recall and save
	typedef enum logic [1:0] {QDF_BOOT, QDF_IDLE, QDF_SAVE, QDF_LOAD} qdf_nvm_e;
endpackage

// ### rtl/qdf_top.sv
`include "qdf_params.svh"
module qdf_top #(
	parameter int LED_SLOW_CYC = `QDF_LED_SLOW_CYC,
	parameter int LED_FAST_CYC = `QDF_LED_FAST_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic adc_convert,
	input wire qdf_pkg::qdf_adc_s adc_in,
	input wire logic trig_in1,
	input wire logic trig_in2,
	output logic trig_out,
	input wire logic ext_interlock,
	input wire logic heater_supply_on,
	output logic quench_relay,
	output logic led_out,
	output logic led_heater,
	output logic led_status,
	output logic [15:0] input_span_select,
	output logic data_format_ascii,
	output qdf_pkg::qdf_nvm_req_s nvm_req,
	input wire qdf_pkg::qdf_nvm_rsp_s nvm_rsp
);
	import qdf_pkg::*;
	// ==========================================
	// Helper functions
	// Byte-lane merge of a bus write
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction
	// Word hit inside a block of n registers
	function automatic logic blk_hit(input logic [7:0] adr, input logic [7:0] base, input int n);
		return (adr >= base) && (adr < base + 8'(4 * n)) && (adr[1:0] == 2'b00);
	endfunction
	// Channels of pair p: 1-2,1-3,1-4,2-3,2-4,3-4
	function automatic logic [3:0] pair_chans(input int p);
		case (p)
			0: return 4'b00_01;
			1: return 4'b00_10;
			2: return 4'b00_11;
			3: return 4'b01_10;
			4: return 4'b01_11;
			default: return 4'b10_11;
		endcase
	endfunction
	// ==========================================
	// Control registers
	logic corr_en_r; // Offset correction on
	logic trig_sync_r; // Trigger realigns sampling
	logic [3:0] win_code_r; // Window length code
	logic [3:0][3:0] span_r; // Span code per channel
	logic [3:0][23:0] abs_thr_r; // Absolute thresholds
	logic [5:0][23:0] pair_thr_r; // Pair thresholds
	logic [3:0][23:0] offset_r; // Signed user offsets
	logic [10:0] status_r; // Sticky quench and interlock bits
	logic [10:0] status_set; // Events this cycle
	logic [10:0] status_clr; // Host clear mask this cycle
	logic save_cmd; // Host asks to save offsets
	logic load_cmd; // Host asks to recall offsets
	qdf_nvm_e nvm_st_r; // Store sequencer
	logic [1:0] nvm_idx_r; // Offset word in transfer
	logic wr_acc; // Bus write taken this cycle
	logic [31:0] rd_mux; // Read data selection
	logic [7:0] ridx; // Offset inside a block
	logic signed [3:0][24:0] reading_r; // Corrected readings
	logic [3:0] pc; // Channel indices of the pair under test
	assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	// ==========================================
	// Wishbone handshake: ack one cycle after the strobe, dropped next cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (clk_en) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end
	// Read decode, unmapped words read zero
	always_comb begin
		rd_mux = 32'h00000000;
		ridx = 8'h00;
		if (wb_adr_i == `QDF_REG_CTRL) begin
			rd_mux[`QDF_CTRL_CORR] = corr_en_r;
			rd_mux[`QDF_CTRL_ASCII] = data_format_ascii;
			rd_mux[`QDF_CTRL_TRIG] = trig_sync_r;
		end else if (wb_adr_i == `QDF_REG_STATUS) begin
			rd_mux[10:0] = status_r;
			rd_mux[`QDF_STAT_BOOT] = (nvm_st_r == QDF_BOOT);
			rd_mux[`QDF_STAT_NVM] = (nvm_st_r != QDF_IDLE);
		end else if (wb_adr_i == `QDF_REG_WINDOW) begin
			rd_mux[3:0] = win_code_r;
		end else if (wb_adr_i == `QDF_REG_SPAN) begin
			rd_mux[15:0] = span_r;
		end else if (blk_hit(wb_adr_i, `QDF_REG_ABS_THR, 4)) begin
			ridx = (wb_adr_i - `QDF_REG_ABS_THR) >> 2;
			rd_mux[23:0] = abs_thr_r[ridx[1:0]];
		end else if (blk_hit(wb_adr_i, `QDF_REG_PAIR_THR, 6)) begin
			ridx = (wb_adr_i - `QDF_REG_PAIR_THR) >> 2;
			rd_mux[23:0] = pair_thr_r[ridx[2:0]];
		end else if (blk_hit(wb_adr_i, `QDF_REG_OFFSET, 4)) begin
			ridx = (wb_adr_i - `QDF_REG_OFFSET) >> 2;
			rd_mux = 32'(signed'(offset_r[ridx[1:0]]));
		end else if (blk_hit(wb_adr_i, `QDF_REG_READING, 4)) begin
			ridx = (wb_adr_i - `QDF_REG_READING) >> 2;
			rd_mux = 32'(signed'(reading_r[ridx[1:0]]));
		end
	end
	// ==========================================
	// Control and threshold writes
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			corr_en_r <= 1'b0;
			data_format_ascii <= 1'b0;
			trig_sync_r <= 1'b0;
			win_code_r <= `QDF_WIN_RST;
			span_r <= {4{`QDF_SPAN_RST}};
			abs_thr_r <= {4{`QDF_ABS_THR_RST}};
			pair_thr_r <= {6{`QDF_PAIR_THR_RST}};
		end else if (clk_en && wr_acc) begin
			for (int c = 0; c < `QDF_NCH; c++) begin
				if (wb_adr_i == `QDF_REG_ABS_THR + 8'(4 * c)) begin
					abs_thr_r[c] <= 24'(lane_merge(32'(abs_thr_r[c]), wb_dat_i, wb_sel_i));
				end
			end
			for (int p = 0; p < `QDF_NPAIR; p++) begin
				if (wb_adr_i == `QDF_REG_PAIR_THR + 8'(4 * p)) begin
					// Unsigned field, so a negative value cannot be stored
					pair_thr_r[p] <= 24'(lane_merge(32'(pair_thr_r[p]), wb_dat_i, wb_sel_i));
				end
			end
			if (wb_adr_i == `QDF_REG_CTRL && wb_sel_i[0]) begin
				corr_en_r <= wb_dat_i[`QDF_CTRL_CORR];
				data_format_ascii <= wb_dat_i[`QDF_CTRL_ASCII];
				trig_sync_r <= wb_dat_i[`QDF_CTRL_TRIG];
			end
			if (wb_adr_i == `QDF_REG_WINDOW && wb_sel_i[0]) begin
				// Lengths above 256 words do not fit the history, so clamp
				win_code_r <= (wb_dat_i[3:0] > `QDF_WIN_MAX) ? `QDF_WIN_MAX : wb_dat_i[3:0];
			end
			if (wb_adr_i == `QDF_REG_SPAN) begin
				for (int c = 0; c < `QDF_NCH; c++) begin
					if (wb_sel_i[c / 2]) begin
						span_r[c] <= (wb_dat_i[c*4 +: 4] > `QDF_SPAN_MAX) ? `QDF_SPAN_MAX : wb_dat_i[c*4 +: 4];
					end
				end
			end
		end
	end
	// Span codes go straight to the gain stages
	assign input_span_select = span_r;
	// ==========================================
	// Command strobes and store sequencer
	assign save_cmd = wr_acc && wb_sel_i[0] && (wb_adr_i == `QDF_REG_CTRL) && wb_dat_i[`QDF_CTRL_SAVE];
	assign load_cmd = wr_acc && wb_sel_i[0] && (wb_adr_i == `QDF_REG_CTRL) && wb_dat_i[`QDF_CTRL_LOAD];
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nvm_st_r <= QDF_BOOT;
			nvm_idx_r <= 2'b00;
			nvm_req <= '0;
			offset_r <= {4{`QDF_OFFSET_RST}};
		end else if (clk_en) begin
			unique case (nvm_st_r)
				QDF_IDLE: begin
					if (save_cmd) begin
						nvm_st_r <= QDF_SAVE;
						nvm_idx_r <= 2'b00;
					end else if (load_cmd) begin
						nvm_st_r <= QDF_LOAD;
						nvm_idx_r <= 2'b00;
					end
					// Host offset writes only while the store is quiet
					for (int c = 0; c < `QDF_NCH; c++) begin
						if (wr_acc && wb_adr_i == `QDF_REG_OFFSET + 8'(4 * c)) begin
							offset_r[c] <= 24'(lane_merge(32'(offset_r[c]), wb_dat_i, wb_sel_i));
						end
					end
				end
				QDF_BOOT, QDF_LOAD, QDF_SAVE: begin
					// Hold the request until the store answers
					nvm_req.req <= !(nvm_req.req && nvm_rsp.ack);
					nvm_req.we <= (nvm_st_r == QDF_SAVE);
					nvm_req.addr <= nvm_idx_r;
					nvm_req.wdata <= offset_r[nvm_idx_r];
					if (nvm_req.req && nvm_rsp.ack) begin
						if (nvm_st_r != QDF_SAVE) begin
							offset_r[nvm_idx_r] <= nvm_rsp.rdata;
						end
						nvm_idx_r <= nvm_idx_r + 2'b01;
						if (nvm_idx_r == 2'b11) begin
							nvm_st_r <= QDF_IDLE;
						end
					end
				end
			endcase
		end
	end
	// ==========================================
	// Sampling clock and trigger
	logic [6:0] smp_cnt_r; // Cycles within one sample period
	logic trig_d_r; // Previous trigger level
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			smp_cnt_r <= 7'h00;
			trig_d_r <= 1'b0;
			adc_convert <= 1'b0;
			trig_out <= 1'b0;
		end else if (clk_en) begin
			trig_d_r <= trig_in1;
			// Second trigger input and trigger output stay unused
			trig_out <= 1'b0;
			if (trig_sync_r && trig_in1 && !trig_d_r) begin
				smp_cnt_r <= 7'h00;
			end else if (smp_cnt_r == 7'(`QDF_SAMPLE_CYC - 1)) begin
				smp_cnt_r <= 7'h00;
			end else begin
				smp_cnt_r <= smp_cnt_r + 7'h01;
			end
			// One convert strobe for all four converters
			adc_convert <= (smp_cnt_r == 7'h00);
		end
	end
	// ==========================================
	// Block decimator: one average per hundred samples
	logic [6:0] dec_cnt_r; // Samples in the current block
	logic [3:0][30:0] dec_acc_r; // Signed block sums
	logic [3:0][23:0] dec_avg_r; // Block averages
	logic dec_valid_r; // New averages ready
	logic [3:0] mean_valid; // Window outputs ready
	logic [3:0][23:0] mean_val; // Window means
	logic read_valid_r; // Readings refreshed
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dec_cnt_r <= 7'h00;
			dec_acc_r <= '0;
			dec_avg_r <= '0;
			dec_valid_r <= 1'b0;
		end else if (clk_en) begin
			dec_valid_r <= 1'b0;
			if (adc_in.valid) begin
				for (int c = 0; c < `QDF_NCH; c++) begin
					if (dec_cnt_r == 7'(`QDF_DECIM_N - 1)) begin
						dec_acc_r[c] <= 31'h00000000;
						dec_avg_r[c] <= 24'((signed'(dec_acc_r[c]) + 31'(signed'(adc_in.data[c]))) / 31'sd100);
					end else begin
						dec_acc_r[c] <= dec_acc_r[c] + 31'(signed'(adc_in.data[c]));
					end
				end
				if (dec_cnt_r == 7'(`QDF_DECIM_N - 1)) begin
					dec_cnt_r <= 7'h00;
					dec_valid_r <= 1'b1;
				end else begin
					dec_cnt_r <= dec_cnt_r + 7'h01;
				end
			end
		end
	end
	// Sliding mean per channel
	for (genvar g = 0; g < `QDF_NCH; g++) begin : g_win
		qdf_window_mean u_win (
			.ref_clk(ref_clk),
			.resetn(resetn),
			.clk_en(clk_en),
			.in_valid(dec_valid_r),
			.in_data(dec_avg_r[g]),
			.win_code(win_code_r),
			.out_valid(mean_valid[g]),
			.out_mean(mean_val[g])
		);
	end
	// ==========================================
	// Reading with optional user offset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reading_r <= '0;
			read_valid_r <= 1'b0;
		end else if (clk_en) begin
			read_valid_r <= mean_valid[0];
			if (mean_valid[0]) begin
				for (int c = 0; c < `QDF_NCH; c++) begin
					reading_r[c] <= 25'(signed'(mean_val[c])) + (corr_en_r ? 25'(signed'(offset_r[c])) : 25'sh0);
				end
			end
		end
	end
	// ==========================================
	// Threshold checks on the same readings
	logic signed [26:0] diff; // Pair difference scratch
	always_comb begin
		status_set = '0;
		diff = 27'sh0;
		pc = 4'h0;
		if (read_valid_r) begin
			for (int c = 0; c < `QDF_NCH; c++) begin
				// Packed elements select unsigned, so re-sign before widening
				status_set[c] = (27'(signed'(reading_r[c])) > signed'({3'b000, abs_thr_r[c]})) ||
					(27'(signed'(reading_r[c])) < -signed'({3'b000, abs_thr_r[c]}));
			end
			for (int p = 0; p < `QDF_NPAIR; p++) begin
				pc = pair_chans(p);
				diff = 27'(signed'(reading_r[pc[3:2]])) - 27'(signed'(reading_r[pc[1:0]]));
				status_set[`QDF_STAT_PAIR_LSB + p] = ((diff < 0) ? -diff : diff) > signed'({3'b000, pair_thr_r[p]});
			end
		end
		status_set[`QDF_STAT_ILK] = ext_interlock;
	end
	// Write-one-to-clear from the host
	assign status_clr = (wr_acc && wb_adr_i == `QDF_REG_STATUS) ?
		11'(lane_merge(32'h00000000, wb_dat_i, wb_sel_i)) : 11'h000;
	// Sticky status, a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= 11'h000;
			quench_relay <= 1'b0;
		end else if (clk_en) begin
			status_r <= (status_r & ~status_clr) | status_set;
			// Interlock bit is reported but does not trip the relay
			quench_relay <= |(((status_r & ~status_clr) | status_set) & 11'h3FF);
		end
	end
	// ==========================================
	// Front lamps
	logic [31:0] led_cnt_r; // Cycles since last toggle
	logic fault; // Any latched status or interlock
	assign fault = |status_r;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			led_cnt_r <= 32'h00000000;
			led_status <= 1'b1;
			led_out <= 1'b1;
			led_heater <= 1'b1;
		end else if (clk_en) begin
			if (nvm_st_r == QDF_BOOT) begin
				// Everything lit until the offsets are back
				led_status <= 1'b1;
				led_out <= 1'b1;
				led_heater <= 1'b1;
				led_cnt_r <= 32'h00000000;
			end else begin
				led_out <= quench_relay;
				led_heater <= heater_supply_on;
				if (led_cnt_r >= 32'((fault ? LED_FAST_CYC : LED_SLOW_CYC) - 1)) begin
					led_cnt_r <= 32'h00000000;
					led_status <= !led_status;
				end else begin
					led_cnt_r <= led_cnt_r + 32'h00000001;
				end
			end
		end
	end
endmodule

// ### rtl/qdf_window_mean.sv
`include "qdf_params.svh"
module qdf_window_mean (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic in_valid,
	input wire logic [23:0] in_data,
	input wire logic [3:0] win_code,
	output logic out_valid,
	output logic [23:0] out_mean
);
	import qdf_pkg::*;
	// ==========================================
	// Storage
	logic [23:0] hist [0:255]; // Last 256 decimated words
	logic [7:0] wr_ptr_r; // Next slot to write
	logic [8:0] fill_r; // Words held, up to window length
	logic signed [31:0] sum_r; // Running sum of the window
	logic signed [31:0] sum_nxt;
	logic [3:0] code_r; // Window code in use
	logic [8:0] len; // Window length in words
	logic drop; // Window full: oldest word leaves
	logic [7:0] old_idx;
	assign len = 9'h001 << code_r;
	assign drop = (fill_r >= len);
	assign old_idx = wr_ptr_r - len[7:0];
	// New sum: add the arrival, drop the word falling out
	always_comb begin
		sum_nxt = sum_r + 32'(signed'(in_data));
		if (drop) begin
			sum_nxt = sum_nxt - 32'(signed'(hist[old_idx]));
		end
	end
	// ==========================================
	// History write, no reset needed since fill count guards reads
	always_ff @(posedge ref_clk) begin
		if (clk_en && in_valid) begin
			hist[wr_ptr_r] <= in_data;
		end
	end
	// Sliding sum and mean
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= 8'h00;
			fill_r <= 9'h000;
			sum_r <= 32'sh0;
			code_r <= `QDF_WIN_RST;
			out_valid <= 1'b0;
			out_mean <= 24'h000000;
		end else if (clk_en) begin
			out_valid <= 1'b0;
			if (code_r != win_code) begin
				// New length: restart so the sum never mixes two windows
				code_r <= win_code;
				fill_r <= 9'h000;
				sum_r <= 32'sh0;
			end else if (in_valid) begin
				wr_ptr_r <= wr_ptr_r + 8'h01;
				sum_r <= sum_nxt;
				if (!drop) begin
					fill_r <= fill_r + 9'h001;
				end
				// Power-of-two length makes the division a shift
				out_mean <= 24'(sum_nxt >>> code_r);
				out_valid <= 1'b1;
			end
		end
	end
endmodule

// ### verification/qdf_far_side.sv
module qdf_far_side #(
	parameter int ACK_DLY = 3
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic adc_convert,
	input wire logic [3:0][23:0] samp,
	output qdf_pkg::qdf_adc_s adc_in,
	input wire qdf_pkg::qdf_nvm_req_s nvm_req,
	output qdf_pkg::qdf_nvm_rsp_s nvm_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	import qdf_pkg::*;
	logic [23:0] mem [4]; // Store keeps words across resets
	int wait_r; // Store answer delay left
	logic busy_r, hold_r; // Serving, or waiting for req low
	initial for (int k = 0; k < 4; k++) mem[k] = 24'(k + 5);
	// ==========
	// Converters: all four channels in one strobe
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			adc_in <= '0;
		end else if (adc_convert) begin
			adc_in <= {1'b1, samp};
		end else begin
			adc_in.valid <= 1'b0;
			adc_in.data <= ~adc_in.data; // Stale data never looks valid
		end
	end
	// ==========
	// Store: answers late, one word per request
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nvm_rsp <= '0;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			wait_r <= 0;
		end else begin
			nvm_rsp.ack <= 1'b0;
			if (!nvm_rsp.ack) nvm_rsp.rdata <= ~nvm_rsp.rdata;
			if (!nvm_req.req) hold_r <= 1'b0;
			if (busy_r && wait_r == 0) begin
				nvm_rsp <= {1'b1, mem[nvm_req.addr]};
				if (nvm_req.we) mem[nvm_req.addr] <= nvm_req.wdata;
				busy_r <= 1'b0;
				hold_r <= 1'b1;
			end else if (busy_r) begin
				wait_r <= wait_r - 1;
			end else if (nvm_req.req && !hold_r) begin
				busy_r <= 1'b1;
				wait_r <= ACK_DLY;
			end
		end
	end
endmodule

// ### verification/qdf_top_asserts.sv
`include "qdf_params.svh"
module qdf_top_asserts
	import qdf_pkg::*;
#(
	parameter int LED_SLOW_CYC = 40,
	parameter int LED_FAST_CYC = 10
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic adc_convert,
	input wire qdf_pkg::qdf_adc_s adc_in,
	input wire logic trig_out,
	input wire logic quench_relay,
	input wire logic led_out,
	input wire logic led_heater,
	input wire logic led_status,
	input wire logic [15:0] input_span_select,
	input wire qdf_pkg::qdf_nvm_req_s nvm_req,
	input wire qdf_pkg::qdf_nvm_rsp_s nvm_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Helpers
	logic [7:0] gap_r; // Cycles since last convert
	logic seen_r; // Gap only valid after a convert
	logic [2:0] acks_r; // Boot answers, stops at 4
	logic take; // Bus request taken here
	logic clr; // Status clear taken here
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
	assign clr = take && wb_we_i && wb_adr_i == `QDF_REG_STATUS;
	// Convert spacing and boot answer count
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gap_r <= 8'h00;
			seen_r <= 1'b0;
			acks_r <= 3'h0;
		end else begin
			gap_r <= adc_convert ? 8'h00 : gap_r + 8'h01;
			seen_r <= seen_r || adc_convert;
			if (nvm_rsp.ack && acks_r < 3'h4) begin
				acks_r <= acks_r + 3'h1;
			end
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// ==========
	// Properties
	chk_ack_next: assert property (take |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	chk_conv_pulse: assert property (adc_convert |=> !adc_convert)
		else $error("convert pulse too long");
	chk_conv_rate: assert property (adc_convert && seen_r |-> gap_r == 8'h63)
		else $error("convert spacing not 100 cycles");
	chk_conv_gap: assert property (seen_r |-> gap_r <= 8'h63)
		else $error("convert missing");
	chk_trig_idle: assert property (!trig_out)
		else $error("trigger output driven");
	chk_boot_lamps: assert property (acks_r < 3'h4 |-> led_out && led_heater && led_status)
		else $error("lamp dark during boot");
	chk_relay_sticky: assert property (quench_relay && !clr |=> quench_relay)
		else $error("relay dropped without clear");
	chk_relay_cause: assert property ($rose(quench_relay) |-> $past(adc_in.valid, 4))
		else $error("relay rose without new block");
	chk_span_write: assert property ($changed(input_span_select) |->
		$past(take && wb_we_i && wb_adr_i == `QDF_REG_SPAN))
		else $error("span changed without write");
	chk_store_hold: assert property (nvm_req.req && !nvm_rsp.ack |=> nvm_req.req && $stable(nvm_req.addr))
		else $error("store request not held");
endmodule
bind qdf_top qdf_top_asserts #(.LED_SLOW_CYC(LED_SLOW_CYC), .LED_FAST_CYC(LED_FAST_CYC)) u_chk (
	.ref_clk, .resetn, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
	.adc_convert, .adc_in, .trig_out, .quench_relay, .led_out, .led_heater, .led_status,
	.input_span_select, .nvm_req, .nvm_rsp);

// ### verification/qdf_top_tb.sv
module qdf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import qdf_pkg::*;
	logic ref_clk, resetn, cyc, stb, we, ack, conv, relay, ascii, ilk, lo, lh, ls, heat;
	logic [3:0] sel;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, dat_o;
	logic [15:0] span;
	logic [3:0][23:0] samp;
	qdf_adc_s adc_in;
	qdf_nvm_req_s nvm_req;
	qdf_nvm_rsp_s nvm_rsp;
	int fail_count, num_checks, nvalid, n;
	int off [4] = '{32'h10, 0, 0, -32'h10}; // Offsets per channel
	int thr [4] = '{32'h1000, 32'h2000, 32'h3000, 32'h4000};
	// ==========
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	qdf_top #(.LED_SLOW_CYC(40), .LED_FAST_CYC(10)) dut (.ref_clk, .resetn, .clk_en(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .adc_convert(conv), .adc_in,
		.trig_in1(1'b0), .trig_in2(1'b0), .trig_out(), .ext_interlock(ilk),
		.heater_supply_on(heat), .quench_relay(relay), .led_out(lo), .led_heater(lh),
		.led_status(ls), .input_span_select(span), .data_format_ascii(ascii), .nvm_req, .nvm_rsp);
	qdf_far_side far (.ref_clk, .resetn, .adc_convert(conv), .samp, .adc_in, .nvm_req, .nvm_rsp);
	// Valid count, to find block edges
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) nvalid <= 0;
		else if (adc_in.valid === 1'b1) nvalid <= nvalid + 1;
	end
	// ==========
	// Tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic guard(input logic ok, input string what);
		if (!ok) begin
			check(32'h0, 32'h1, what);
			end_of_test();
		end
	endtask
	// One classic cycle; held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		guard(ack === 1'b1, "bus timeout");
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		check(rdat, exp, what);
	endtask
	// Status settles four edges after the hundredth valid
	task automatic wait_block();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (!(adc_in.valid === 1'b1 && nvalid % 100 == 99) && k < 30000);
		guard(k < 30000, "block timeout");
		repeat (6) @(posedge ref_clk);
	endtask
	// New samples for one whole block, then readings and status
	task automatic step(input int v0, v1, v2, v3, input logic [31:0] st);
		int v [4];
		v = '{v0, v1, v2, v3};
		samp <= {24'(v3), 24'(v2), 24'(v1), 24'(v0)};
		wait_block();
		for (int k = 0; k < 4; k++) rd_chk(8'h50 + 8'(4 * k), 32'(v[k] + off[k]), "reading");
		rd_chk(8'h04, st, "status");
		check({31'h0, relay}, {31'h0, |st[9:0]}, "relay");
		check({31'h0, lo}, {31'h0, |st[9:0]}, "out lamp");
	endtask
	// Lamp half period, measured between two toggles
	task automatic lamp(input int exp);
		int k;
		logic l;
		for (int j = 0; j < 2; j++) begin
			k = 0;
			l = ls;
			while (ls === l && k < 200) begin
				@(posedge ref_clk);
				k++;
			end
		end
		check(32'(k), 32'(exp), "lamp period");
	endtask
	// ==========
	// Sequence
	initial begin
		{resetn, cyc, stb, we, ilk, adr, wdat, samp} = '0;
		sel = 4'hF;
		heat = 1'b1;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		n = 0;
		do wb(1'b0, 8'h04, 32'h0); while (rdat[11] !== 1'b0 && ++n < 100);
		guard(rdat[11] === 1'b0, "boot timeout");
		for (int k = 0; k < 4; k++) rd_chk(8'h40 + 8'(4 * k), 32'(k + 5), "recall");
		rd_chk(8'h08, 32'h4, "window reset");
		for (int k = 0; k < 4; k++) rd_chk(8'h10 + 8'(4 * k), 32'h7FFFFF, "abs reset");
		rd_chk(8'h20, 32'hFFFFFF, "pair reset");
		// Heater lamp follows its input once boot is over
		heat <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({31'h0, lh}, 32'h0, "heater lamp");
		// Only the low byte lane may change
		sel <= 4'h1;
		wb(1'b1, 8'h10, 32'h55);
		sel <= 4'hF;
		rd_chk(8'h10, 32'h7FFF55, "byte lane");
		wb(1'b1, 8'hFC, 32'h12345678);
		rd_chk(8'hFC, 32'h0, "unmapped");
		wb(1'b1, 8'h08, 32'hF);
		rd_chk(8'h08, 32'h8, "window clamp");
		wb(1'b1, 8'h0C, 32'hA0F3);
		check({16'h0, span}, 32'hA0A3, "span");
		wb(1'b1, 8'h00, 32'h3);
		check({31'h0, ascii}, 32'h1, "text format");
		wb(1'b1, 8'h00, 32'h1);
		check({31'h0, ascii}, 32'h0, "double format");
		for (int k = 0; k < 4; k++) wb(1'b1, 8'h40 + 8'(4 * k), 32'(off[k]));
		for (int k = 0; k < 4; k++) rd_chk(8'h40 + 8'(4 * k), 32'(off[k]), "offset");
		for (int k = 0; k < 4; k++) wb(1'b1, 8'h10 + 8'(4 * k), 32'(thr[k]));
		for (int k = 0; k < 6; k++) wb(1'b1, 8'h20 + 8'(4 * k), k == 3 ? 32'h500 : 32'h100000);
		wb(1'b1, 8'h08, 32'h0);
		lamp(40);
		wait_block();
		step(32'h100, 32'h200, -32'h300, 32'h400, 32'h0);
		step(32'hFF0, 32'h200, -32'h3001, 32'h400, 32'h84);
		step(32'h100, 32'h200, -32'h300, 32'h400, 32'h84);
		wb(1'b1, 8'h04, 32'h84);
		rd_chk(8'h04, 32'h0, "status clear");
		check({31'h0, relay}, 32'h0, "relay clear");
		step(32'h100, 32'h300, -32'h300, 32'h4010, 32'h80);
		@(posedge ref_clk);
		ilk <= 1'b1;
		@(posedge ref_clk);
		ilk <= 1'b0;
		rd_chk(8'h04, 32'h480, "interlock");
		lamp(10);
		wb(1'b1, 8'h00, 32'h9);
		n = 0;
		do wb(1'b0, 8'h04, 32'h0); while (rdat[12] !== 1'b0 && ++n < 100);
		guard(rdat[12] === 1'b0, "save timeout");
		for (int k = 0; k < 4; k++) check({8'h0, far.mem[k]}, {8'h0, 24'(off[k])}, "saved");
		end_of_test();
	end
endmodule
